// file: hw/asc_host.sv
// host end: command fifo, frame sequencer, divided serial clock
// assumes spi_mode matches the devices' write protocol field
`include "asc_defines.svh"

// fifo with registered flags, valid/ready on both sides
module asc_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] wp;
	logic [$clog2(DEPTH)-1:0] rp;
	logic push;
	logic pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rp];

	// pointers, count and flags
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			count <= count + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
			in_ready <= (count + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop})
				!= ($clog2(DEPTH) + 1)'(DEPTH);
			out_valid <= (count + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop})
				!= '0;
		end
	end

	// storage has no reset
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end
endmodule : asc_fifo

module asc_host (
	input wire logic ref_clk,
	input wire logic rstn,
	asc_if.host bus,
	input wire logic [1:0] spi_mode,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire asc_pkg::asc_word_t cmd_data,
	output logic rsp_valid,
	output asc_pkg::asc_word_t rsp_data
);
	import asc_pkg::*;

	asc_host_st_t st;
	asc_host_st_t next_st;
	logic q_valid;
	logic q_pop;
	asc_word_t q_data;
	logic [4:0] q_count;
	logic lead;
	logic capture;
	logic launch;

	asc_fifo #(.WIDTH(`ASC_USR_W), .DEPTH(`ASC_FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.in_valid(cmd_valid),
		.in_ready(cmd_ready),
		.in_data(cmd_data),
		.out_valid(q_valid),
		.out_ready(q_pop),
		.out_data(q_data),
		.count(q_count)
	);

	// sequencer: trigger, full-length frame, optional wake wait
	always_comb begin
		next_st = st;
		next_st.ms = {st.ms[0], bus.serial_out_lane0};
		next_st.rsp_valid = 1'b0;
		q_pop = 1'b0;
		lead = !st.edges[0];
		capture = spi_mode[0] ? !lead : lead;
		launch = spi_mode[0] ? lead : !lead;
		case (st.state)
			H_IDLE: begin
				next_st.sclk = spi_mode[1];
				// a frame starts only with every chain word queued
				if (q_count >= 5'(`ASC_CHAIN_N)) begin
					next_st.state = H_TRIG;
					next_st.trig = 1'b1;
					next_st.cnt = '0;
				end
			end
			H_TRIG: begin
				next_st.cnt = st.cnt + 16'h0001;
				if (st.cnt == 16'(`ASC_TRIG_CYC - 1)) begin
					next_st.trig = 1'b0;
					next_st.cs_n = 1'b0;
					next_st.tx = q_data;
					next_st.mosi = q_data[`ASC_USR_W-1];
					q_pop = 1'b1;
					next_st.pd_seen = q_data[`ASC_OP_HI:`ASC_OP_LO] == `ASC_OP_WR
						&& q_data[`ASC_ADDR_HI:`ASC_ADDR_LO] == `ASC_A_PD;
					next_st.words = 4'h1;
					next_st.edges = '0;
					next_st.bitcnt = '0;
					next_st.cnt = '0;
					next_st.state = H_SHIFT;
				end
			end
			H_SHIFT: begin
				next_st.cnt = st.cnt + 16'h0001;
				if (st.cnt == 16'(`ASC_HALF_CYC - 1)) begin
					next_st.cnt = '0;
					if (st.edges == 8'(2 * `ASC_USR_W * `ASC_CHAIN_N)) begin
						next_st.cs_n = 1'b1;
						next_st.state = H_END;
					end else begin
						next_st.sclk = !st.sclk;
						next_st.edges = st.edges + 8'h01;
						if (capture) begin
							next_st.rx = {st.rx[`ASC_USR_W-2:0], st.ms[1]};
							next_st.tx = {st.tx[`ASC_USR_W-2:0], 1'b0};
							next_st.bitcnt = st.bitcnt + 5'h01;
							if (st.bitcnt == 5'(`ASC_USR_W - 1)) begin
								next_st.bitcnt = '0;
								next_st.rsp_valid = 1'b1;
								next_st.rsp_data = {st.rx[`ASC_USR_W-2:0], st.ms[1]};
								if (st.words < 4'(`ASC_CHAIN_N)) begin
									// next chain word follows back to back
									next_st.tx = q_data;
									q_pop = 1'b1;
									next_st.words = st.words + 4'h1;
									if (q_data[`ASC_OP_HI:`ASC_OP_LO] == `ASC_OP_WR
										&& q_data[`ASC_ADDR_HI:`ASC_ADDR_LO] == `ASC_A_PD) begin
										next_st.pd_seen = 1'b1;
									end
								end
							end
						end
						if (launch) begin
							next_st.mosi = st.tx[`ASC_USR_W-1];
						end
					end
				end
			end
			H_END: begin
				next_st.cnt = st.cnt + 16'h0001;
				if (st.cnt == 16'(`ASC_HALF_CYC - 1)) begin
					next_st.cnt = '0;
					next_st.state = st.pd_seen ? H_WAKE : H_IDLE;
				end
			end
			H_WAKE: begin
				// covers both converter and buffer wake-up
				next_st.cnt = st.cnt + 16'h0001;
				if (st.cnt == 16'(`ASC_WAKE_CYC - 1)) begin
					next_st.state = H_IDLE;
				end
			end
			default: begin
				next_st.state = H_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.state <= H_IDLE;
			st.cs_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign bus.cs_n = st.cs_n;
	assign bus.sclk = st.sclk;
	assign bus.sample_trigger = st.trig;
	assign bus.sdi = st.mosi;
	assign rsp_valid = st.rsp_valid;
	assign rsp_data = st.rsp_data;
endmodule : asc_host

// file: hw/asc_defines.svh
// constants of the chained converter serial port: offsets, fields, timing
// assumes a 100 MHz ref_clk; included by the package and by each end
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// unified shift chain and command word layout
`define ASC_USR_W 22
`define ASC_OP_HI 21
`define ASC_OP_LO 19
`define ASC_ADDR_HI 18
`define ASC_ADDR_LO 10
`define ASC_DATA_HI 9
`define ASC_DATA_LO 2
`define ASC_OP_WR 3'h5
`define ASC_OP_RD 3'h4
`define ASC_SAMPLE_W 18

// configuration register offsets
`define ASC_REG_NUM 9
`define ASC_A_PD 9'h004
`define ASC_A_WPROTO 9'h008
`define ASC_A_RPROTO 9'h00c
`define ASC_A_DCFG 9'h010
`define ASC_A_PAT_LO 9'h014
`define ASC_A_PAT_MID 9'h015
`define ASC_A_PAT_HI 9'h016
`define ASC_A_OFST 9'h020
`define ASC_A_REFM 9'h030

// writable masks and reset value
`define ASC_M_PD 8'h06
`define ASC_M_WPROTO 8'h03
`define ASC_M_RPROTO 8'hdf
`define ASC_M_DCFG 8'h0f
`define ASC_M_PAT_HI 8'h0f
`define ASC_M_FULL 8'hff
`define ASC_REG_RST 8'h00

// field positions
`define ASC_REFERENCE_BUFFER_OFF_BIT 2
`define ASC_PD_CONV_BIT 1
`define ASC_WP_CPOL_BIT 1
`define ASC_WP_CPHA_BIT 0
`define ASC_DCFG_PAT_BIT 0

// host timing
`define ASC_CLK_NS 10
`define ASC_CHAIN_N 2
`define ASC_HALF_CYC 10
`define ASC_TRIG_CYC 10
`define ASC_CONV_WAKE_NS 1000
`define ASC_REF_WAKE_NS 2000
`define ASC_CONV_WAKE_CYC ((`ASC_CONV_WAKE_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_REF_WAKE_CYC ((`ASC_REF_WAKE_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_WAKE_CYC ((`ASC_CONV_WAKE_CYC > `ASC_REF_WAKE_CYC) ? `ASC_CONV_WAKE_CYC : `ASC_REF_WAKE_CYC)
`define ASC_FIFO_DEPTH 16

`endif

// file: hw/asc_pkg.sv
// types shared by the device end and the host end
// assumes asc_defines.svh is on the include path
`include "asc_defines.svh"

package asc_pkg;
	typedef logic [`ASC_USR_W-1:0] asc_word_t;
	typedef logic [7:0] asc_byte_t;
	typedef logic [`ASC_SAMPLE_W-1:0] asc_sample_t;

	typedef enum logic [2:0] {
		H_IDLE,
		H_TRIG,
		H_SHIFT,
		H_END,
		H_WAKE
	} asc_hstate_t;

	// device state
	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] ck_s;
		logic [2:0] tr_s;
		logic [1:0] di_s;
		asc_word_t unified_shift_chain;
		logic sdo;
		logic sdo_oe_n;
		asc_sample_t sample;
		logic sample_stb;
		logic [`ASC_REG_NUM-1:0][7:0] cfg;
		logic rd_pend;
		asc_byte_t rd_data;
		logic conv_off;
		logic ref_off;
	} asc_dev_st_t;

	// host state
	typedef struct packed {
		asc_hstate_t state;
		logic [15:0] cnt;
		logic [7:0] edges;
		logic [4:0] bitcnt;
		logic [3:0] words;
		asc_word_t tx;
		asc_word_t rx;
		logic sclk;
		logic cs_n;
		logic trig;
		logic mosi;
		logic [1:0] ms;
		logic rsp_valid;
		asc_word_t rsp_data;
		logic pd_seen;
	} asc_host_st_t;
endpackage : asc_pkg

// file: hw/asc_if.sv
// link wires between the host end and one device end
// assumes the lane idles high when released (pull-up model)
interface asc_if;
	logic cs_n;
	logic sclk;
	logic sample_trigger;
	logic sdi;
	logic sdo_o;
	logic sdo_oe_n;
	logic serial_out_lane0;

	// resolved lane level from the device enable
	assign serial_out_lane0 = sdo_oe_n ? 1'b1 : sdo_o;

	modport dev (
		input cs_n,
		input sclk,
		input sample_trigger,
		input sdi,
		output sdo_o,
		output sdo_oe_n
	);

	modport host (
		output cs_n,
		output sclk,
		output sample_trigger,
		output sdi,
		input serial_out_lane0
	);
endinterface : asc_if

// file: hw/asc_dev.sv
// device end: unified shift chain, config registers, power-down controls
// assumes link pins arrive asynchronously and conv_data is on ref_clk
`include "asc_defines.svh"

// Behaviour
// - host writes identical configs, legacy protocols only; the bench writes different pattern bytes (11h, 22h) to the two devices
// - output and input registers form one 22-bit chain
// - capture sample on trigger rising edge
// - frame begins at chip select falling
// - launch edge drives chain msb onto lane
// - capture edge shifts input into chain lsb
// - chip select rising decodes and executes command
// - host gives 22 times N clocks per frame
// - longer frames need host word alignment
// - host never sends short chained frames
// - star: only one chip select low
// - reset input acts asynchronously
// - nine byte registers, 004h through 030h
// - power-down bit 2 turns reference buffer off
// - power-down bit 1 turns converter off
// - converter off change acts at select rise
// - host waits converter wake-up time
// - buffer off change acts at select rise
// - host waits buffer wake-up time
// - power-down reserved bits read zero
// - write protocol resets zero, two bits writable
// - write protocol field picks polarity and phase
// - output follows write protocol clock mode
module asc_dev (
	input wire logic ref_clk,
	input wire logic rstn,
	asc_if.dev bus,
	input wire asc_pkg::asc_sample_t conv_data,
	output logic sample_strobe,
	output asc_pkg::asc_sample_t sample_word,
	output logic converter_off,
	output logic reference_buffer_off,
	output logic [1:0] write_protocol_field
);
	import asc_pkg::*;

	asc_dev_st_t st;
	asc_dev_st_t next_st;

	// map an offset to a register slot, REG_NUM when unmapped
	function automatic logic [3:0] reg_index(input logic [8:0] addr);
		case (addr)
			`ASC_A_PD: reg_index = 4'h0;
			`ASC_A_WPROTO: reg_index = 4'h1;
			`ASC_A_RPROTO: reg_index = 4'h2;
			`ASC_A_DCFG: reg_index = 4'h3;
			`ASC_A_PAT_LO: reg_index = 4'h4;
			`ASC_A_PAT_MID: reg_index = 4'h5;
			`ASC_A_PAT_HI: reg_index = 4'h6;
			`ASC_A_OFST: reg_index = 4'h7;
			`ASC_A_REFM: reg_index = 4'h8;
			default: reg_index = 4'h9;
		endcase
	endfunction : reg_index

	// writable bits per slot; reserved bits stay zero
	function automatic asc_byte_t reg_mask(input logic [3:0] idx);
		case (idx)
			4'h0: reg_mask = `ASC_M_PD;
			4'h1: reg_mask = `ASC_M_WPROTO;
			4'h2: reg_mask = `ASC_M_RPROTO;
			4'h3: reg_mask = `ASC_M_DCFG;
			4'h6: reg_mask = `ASC_M_PAT_HI;
			4'h4, 4'h5, 4'h7, 4'h8: reg_mask = `ASC_M_FULL;
			default: reg_mask = 8'h00;
		endcase
	endfunction : reg_mask

	logic cs;
	logic cs_prev;
	logic ck_rise;
	logic ck_fall;
	logic lead;
	logic trail;
	logic capture;
	logic launch;
	logic cpol;
	logic cpha;
	logic [3:0] idx;
	asc_word_t frame_word;
	asc_byte_t wr_val;
	asc_byte_t pd_new;

	// edge finding on the synchronised pins
	always_comb begin
		cs = st.cs_s[1];
		cs_prev = st.cs_s[2];
		cpol = st.cfg[0 + 1][`ASC_WP_CPOL_BIT];
		cpha = st.cfg[0 + 1][`ASC_WP_CPHA_BIT];
		ck_rise = st.ck_s[1] & ~st.ck_s[2];
		ck_fall = ~st.ck_s[1] & st.ck_s[2];
		lead = cpol ? ck_fall : ck_rise;
		trail = cpol ? ck_rise : ck_fall;
		// the read side shares the write side mode
		capture = cpha ? trail : lead;
		launch = cpha ? lead : trail;
	end

	// word loaded into the chain when a frame opens
	always_comb begin
		if (st.rd_pend) begin
			frame_word = {st.rd_data, 14'h0000};
		end else if (st.cfg[3][`ASC_DCFG_PAT_BIT]) begin
			frame_word = {st.cfg[6][3:0], st.cfg[5], st.cfg[4], 2'h0};
		end else begin
			frame_word = {st.sample, 4'h0};
		end
	end

	// command decode of the finished chain contents
	always_comb begin
		idx = reg_index(st.unified_shift_chain[`ASC_ADDR_HI:`ASC_ADDR_LO]);
		wr_val = st.unified_shift_chain[`ASC_DATA_HI:`ASC_DATA_LO] & reg_mask(idx);
		if (st.unified_shift_chain[`ASC_OP_HI:`ASC_OP_LO] == `ASC_OP_WR && idx == 4'h0) begin
			pd_new = wr_val;
		end else begin
			pd_new = st.cfg[0];
		end
	end

	// next state of the whole device
	always_comb begin
		next_st = st;
		// two flops before any use, a third for edges
		next_st.cs_s = {st.cs_s[1:0], bus.cs_n};
		next_st.ck_s = {st.ck_s[1:0], bus.sclk};
		next_st.tr_s = {st.tr_s[1:0], bus.sample_trigger};
		next_st.di_s = {st.di_s[0], bus.sdi};
		next_st.sample_stb = 1'b0;

		// sample only while the converter is powered
		if (st.tr_s[1] && !st.tr_s[2] && !st.conv_off) begin
			next_st.sample = conv_data;
			next_st.sample_stb = 1'b1;
		end

		if (cs_prev && !cs) begin
			// frame opens: load chain and drive its msb
			next_st.unified_shift_chain = frame_word;
			next_st.sdo = frame_word[`ASC_USR_W-1];
			next_st.sdo_oe_n = 1'b0;
		end else if (!cs) begin
			if (capture) begin
				// one chain for both directions
				next_st.unified_shift_chain = {st.unified_shift_chain[`ASC_USR_W-2:0], st.di_s[1]};
			end
			if (launch) begin
				next_st.sdo = st.unified_shift_chain[`ASC_USR_W-1];
			end
		end

		if (!cs_prev && cs) begin
			// frame closes: release lane, act on the command
			next_st.sdo_oe_n = 1'b1;
			next_st.rd_pend = 1'b0;
			case (st.unified_shift_chain[`ASC_OP_HI:`ASC_OP_LO])
				`ASC_OP_WR: begin
					if (idx < 4'h9) begin
						next_st.cfg[idx] = wr_val;
					end
				end
				`ASC_OP_RD: begin
					next_st.rd_pend = 1'b1;
					next_st.rd_data = (idx < 4'h9) ? st.cfg[idx] : 8'h00;
				end
				default: begin
					next_st.rd_pend = 1'b0;
				end
			endcase
			// power changes take hold only at this edge
			next_st.conv_off = pd_new[`ASC_PD_CONV_BIT];
			next_st.ref_off = pd_new[`ASC_REFERENCE_BUFFER_OFF_BIT];
		end
	end

	// state register, async active-low reset
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st.cs_s <= 3'h7;
			st.ck_s <= 3'h0;
			st.tr_s <= 3'h0;
			st.di_s <= 2'h0;
			st.unified_shift_chain <= '0;
			st.sdo <= 1'b0;
			st.sdo_oe_n <= 1'b1;
			st.sample <= '0;
			st.sample_stb <= 1'b0;
			st.cfg <= {`ASC_REG_NUM{`ASC_REG_RST}};
			st.rd_pend <= 1'b0;
			st.rd_data <= 8'h00;
			st.conv_off <= 1'b0;
			st.ref_off <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign bus.sdo_o = st.sdo;
	assign bus.sdo_oe_n = st.sdo_oe_n;
	assign sample_strobe = st.sample_stb;
	assign sample_word = st.sample;
	assign converter_off = st.conv_off;
	assign reference_buffer_off = st.ref_off;
	assign write_protocol_field = st.cfg[1][1:0];
endmodule : asc_dev

// file: tb/asc_monitor.sv
// checker on the host-side link of the two-device chain
// assumes clock polarity 0, spi_mode as the host uses it, ASC_CHAIN_N devices
`include "asc_defines.svh"
module asc_monitor (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [1:0] spi_mode,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sample_trigger,
	input wire logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe_n,
	input wire logic serial_out_lane0
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int FRAME_EDGES = 2 * `ASC_USR_W * `ASC_CHAIN_N;
	logic sclk_q;
	logic cs_q;
	logic [7:0] edge_cnt;
	logic cap_edge;

	// capture edge of the serial clock for the selected phase and polarity
	assign cap_edge = sclk != sclk_q && sclk == !(spi_mode[1] ^ spi_mode[0]);

	default clocking mon_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// counts serial clock edges since the frame opened
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			edge_cnt <= 8'h00;
		end else begin
			sclk_q <= sclk;
			cs_q <= cs_n;
			if (cs_q && !cs_n) begin
				edge_cnt <= 8'h00;
			end else if (!cs_n && sclk != sclk_q) begin
				edge_cnt <= edge_cnt + 8'h01;
			end
		end
	end

	// link-level relations
	a_lane_released: assert property (cs_n [*7] |-> sdo_oe_n && serial_out_lane0)
		else $error("lane still driven while deselected");
	a_lane_driven: assert property ($fell(cs_n) |-> ##[1:6] !sdo_oe_n)
		else $error("lane not driven after frame open");
	a_sclk_quiet: assert property (cs_n && $past(cs_n) |-> !sclk && $stable(sclk))
		else $error("serial clock moving outside a frame");
	a_frame_edges: assert property ($rose(cs_n) |-> edge_cnt == FRAME_EDGES)
		else $error("frame closed with wrong edge count");
	a_sdo_hold: assert property (!cs_n && cap_edge |-> ##1 $stable(sdo_o) [*6])
		else $error("lane changed away from launch edge");
	a_sdi_capture: assert property (!cs_n && cap_edge |-> $stable(sdi) ##1 $stable(sdi))
		else $error("host data moved at capture edge");
	a_trig_outside: assert property ($rose(sample_trigger) |-> cs_n ##1 cs_n)
		else $error("trigger raised inside a frame");
	a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*8])
		else $error("frame reopened too soon");
endmodule : asc_monitor

// file: tb/adc_spi_chain_and_power_ctrl_test.sv
// bench: host end driving a chain of two device ends
// assumes clock polarity 0; phase 0 first, phase 1 later; package constants
`include "asc_defines.svh"
module adc_spi_chain_and_power_ctrl_test import asc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam asc_sample_t CONV_A = 18'h2a5a5;
	localparam asc_sample_t CONV_B = 18'h1c3c3;
	localparam asc_word_t SMP_A = {CONV_A, 4'h0};
	localparam asc_word_t SMP_B = {CONV_B, 4'h0};
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	asc_word_t cmd_data = 22'h0;
	logic cmd_ready;
	logic rsp_valid;
	asc_word_t rsp_data;
	asc_sample_t sw [2];
	logic coff [2];
	logic roff [2];
	logic [1:0] wpf [2];
	logic stb [2];
	logic [1:0] mode = 2'h0;
	int n_stb [2] = '{0, 0};
	logic mid_off;
	logic full;
	int num_errors = 0;
	int n_checks = 0;
	int n_acc;
	asc_word_t r;

	asc_if h_if ();
	asc_if a_if ();
	asc_if b_if ();

	// chain wiring: host -> first device -> second device -> host
	assign a_if.cs_n = h_if.cs_n;
	assign a_if.sclk = h_if.sclk;
	assign a_if.sample_trigger = h_if.sample_trigger;
	assign a_if.sdi = h_if.sdi;
	assign b_if.cs_n = h_if.cs_n;
	assign b_if.sclk = h_if.sclk;
	assign b_if.sample_trigger = h_if.sample_trigger;
	assign b_if.sdi = a_if.serial_out_lane0;
	assign h_if.sdo_o = b_if.sdo_o;
	assign h_if.sdo_oe_n = b_if.sdo_oe_n;

	asc_host asc_host_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(h_if.host), .spi_mode(mode),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	asc_dev asc_dev_inst_1 (.ref_clk(ref_clk), .rstn(rstn), .bus(a_if.dev), .conv_data(CONV_A),
		.sample_strobe(stb[0]), .sample_word(sw[0]), .converter_off(coff[0]),
		.reference_buffer_off(roff[0]), .write_protocol_field(wpf[0]));
	asc_dev asc_dev_inst_2 (.ref_clk(ref_clk), .rstn(rstn), .bus(b_if.dev), .conv_data(CONV_B),
		.sample_strobe(stb[1]), .sample_word(sw[1]), .converter_off(coff[1]),
		.reference_buffer_off(roff[1]), .write_protocol_field(wpf[1]));
	asc_monitor asc_monitor_inst (.ref_clk(ref_clk), .rstn(rstn), .spi_mode(mode),
		.cs_n(h_if.cs_n), .sclk(h_if.sclk), .sample_trigger(h_if.sample_trigger), .sdi(h_if.sdi),
		.sdo_o(h_if.sdo_o), .sdo_oe_n(h_if.sdo_oe_n), .serial_out_lane0(h_if.serial_out_lane0));

	// 100 MHz system clock
	always #5 ref_clk = ~ref_clk;

	// count sample strobes per device, away from the launching edge
	always @(negedge ref_clk) begin
		if (stb[0] === 1'b1) n_stb[0]++;
		if (stb[1] === 1'b1) n_stb[1]++;
	end

	function automatic asc_word_t cmd(input logic [2:0] op, input logic [8:0] a, input asc_byte_t d);
		return {op, a, d, 2'b00};
	endfunction : cmd

	task automatic check(input asc_word_t seen, input asc_word_t exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic give_up;
		num_errors++;
		$display("BAD %0t wait ran out", $time);
		report_and_stop();
	endtask : give_up

	// one command word into the host queue
	task automatic push(input asc_word_t w);
		logic ok;
		ok = 1'b0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_data <= w;
		for (int i = 0; i < 3000 && !ok; i++) begin
			@(negedge ref_clk);
			ok = (cmd_ready === 1'b1);
			@(posedge ref_clk);
		end
		cmd_valid <= 1'b0;
		if (!ok) give_up();
	endtask : push

	task automatic get_rsp(output asc_word_t w);
		for (int i = 0; i < 3000; i++) begin
			@(negedge ref_clk);
			if (rsp_valid === 1'b1) begin
				w = rsp_data;
				return;
			end
		end
		give_up();
	endtask : get_rsp

	// one chained frame; first word ends in the far device, whose data returns first
	task automatic step(input asc_word_t wl, input asc_word_t wf, input asc_word_t e0,
		input asc_word_t e1);
		asc_word_t r0;
		asc_word_t r1;
		push(wl);
		push(wf);
		get_rsp(r0);
		mid_off = coff[0] | coff[1] | roff[0] | roff[1];
		get_rsp(r1);
		check(r0, e0);
		check(r1, e1);
		for (int i = 0; i < 200 && h_if.cs_n !== 1'b1; i++) begin
			@(negedge ref_clk);
		end
		if (h_if.cs_n !== 1'b1) give_up();
		repeat (6) @(negedge ref_clk);
	endtask : step

	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(negedge ref_clk);
		check(22'({coff[0], coff[1], roff[0], roff[1]}), 22'h0);
		check(22'({wpf[0], wpf[1]}), 22'h0);
		check(22'({h_if.sdo_oe_n, h_if.serial_out_lane0, cmd_ready}), 22'h7);
		step(22'h0, 22'h0, SMP_B, SMP_A);
		check(22'(sw[0]), 22'(CONV_A));
		check(22'(sw[1]), 22'(CONV_B));
		check(22'(n_stb[0] * 16 + n_stb[1]), 22'h11);
		step(cmd(3'h5, 9'h004, 8'hff), cmd(3'h5, 9'h004, 8'hff), SMP_B, SMP_A);
		check({21'h0, mid_off}, 22'h0);
		check(22'({coff[0], coff[1], roff[0], roff[1]}), 22'hf);
		step(cmd(3'h4, 9'h004, 8'h00), cmd(3'h4, 9'h004, 8'h00), SMP_B, SMP_A);
		step(cmd(3'h5, 9'h014, 8'h11), cmd(3'h5, 9'h014, 8'h22), 22'h6 << 14, 22'h6 << 14);
		step(cmd(3'h4, 9'h014, 8'h00), cmd(3'h4, 9'h014, 8'h00), SMP_B, SMP_A);
		step(cmd(3'h5, 9'h008, 8'hfc), cmd(3'h5, 9'h004, 8'h00), 22'h11 << 14, 22'h22 << 14);
		check(22'({coff[0], coff[1], roff[0], roff[1]}), 22'h5);
		step(cmd(3'h4, 9'h008, 8'h00), cmd(3'h4, 9'h005, 8'h00), SMP_B, SMP_A);
		check(22'(n_stb[0] * 16 + n_stb[1]), 22'h32);
		step(22'h0, 22'h0, 22'h0, 22'h0);
		check(22'({wpf[0], wpf[1]}), 22'h0);
		// phase 1 for the rest of the run, with one frame of pattern words on the way
		step(cmd(3'h5, 9'h008, 8'h01), cmd(3'h5, 9'h008, 8'h01), SMP_B, SMP_A);
		check(22'({wpf[0], wpf[1]}), 22'h5);
		@(posedge ref_clk);
		mode <= 2'h1;
		step(cmd(3'h5, 9'h010, 8'h01), cmd(3'h5, 9'h010, 8'h01), SMP_B, SMP_A);
		step(cmd(3'h4, 9'h008, 8'h00), cmd(3'h4, 9'h008, 8'h00), 22'h44, 22'h88);
		step(cmd(3'h5, 9'h010, 8'h00), cmd(3'h5, 9'h010, 8'h00), 22'h4000, 22'h4000);
		// fill the command queue until it refuses, then drain whole frames
		n_acc = 0;
		full = 1'b0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_data <= 22'h0;
		for (int i = 0; i < 40 && !full; i++) begin
			@(negedge ref_clk);
			full = !cmd_ready;
			@(posedge ref_clk);
			if (!full) n_acc++;
		end
		cmd_valid <= 1'b0;
		check({21'h0, full}, 22'h1);
		for (int i = 0; i < (n_acc & ~1); i++) begin
			get_rsp(r);
			check(r, i[0] ? SMP_A : SMP_B);
		end
		report_and_stop();
	end
endmodule : adc_spi_chain_and_power_ctrl_test
